//--- hdl/ilx_load_unit.sv
// integer byte and half-word zero-extending load execution unit
//
// What this block does
// [RQ1] displacement EA is base plus displacement
// [RQ2] indexed EA is base plus index register
// [RQ3] byte load fills low byte, rest zero
// [RQ4] half-word load fills low half, rest zero
// [RQ5] update form writes EA to base register
// [RQ6] update with base zero writes EA to register zero
// [RQ7] base equals destination keeps loaded data
// [RQ8] displacement sign-extended from 16 to 32 bits
// [RQ9] zero base field adds literal zero
// [RQ10] one or two byte access, same data
//
// bit numbering: big-endian bits 24:31 are our [7:0], bits 16:31 our [15:0].
`timescale 1ns/1ps

module ilx_load_unit (
	input  wire logic             sys_clk,    // core clock, 20 MHz
	input  wire logic             rstn,       // synchronous reset, active low
	input  wire logic             req_valid,  // decoded load offered
	input  ilx_pkg::ilx_req_s     req,        // decoded load and operands
	output logic                  req_ready,  // unit idle, request taken
	output logic                  mem_valid,  // one-cycle memory request strobe
	output ilx_pkg::ilx_mem_s     mem,        // address and size, held to next request
	input  wire logic             rsp_valid,  // memory data returned
	input  wire logic [31:0]      rsp_data,   // element right-aligned in [15:0]/[7:0]
	output ilx_pkg::ilx_wb_s      wb_dest,    // destination write, one-cycle enable
	output ilx_pkg::ilx_wb_s      wb_base     // base write-back, one-cycle enable
);
	typedef enum logic {
		ST_IDLE,
		ST_WAIT
	} ilx_state_e;

	ilx_state_e        state_ff;
	ilx_state_e        nxt_state;
	logic              ready_ff;
	logic              mem_valid_ff;
	ilx_pkg::ilx_mem_s mem_ff;
	ilx_pkg::ilx_wb_s  wb_dest_ff;
	ilx_pkg::ilx_wb_s  wb_base_ff;
	logic              half_ff;
	logic              upd_ff;
	logic [4:0]        dest_ff;
	logic [4:0]        base_idx_ff;

	// opcode decode
	wire op_half    = req.op inside {ilx_pkg::OP_LDH, ilx_pkg::OP_LDH_X,
		ilx_pkg::OP_LDH_U, ilx_pkg::OP_LDH_UX};
	wire op_indexed = req.op inside {ilx_pkg::OP_LDB_X, ilx_pkg::OP_LDB_UX,
		ilx_pkg::OP_LDH_X, ilx_pkg::OP_LDH_UX};
	wire op_update  = req.op inside {ilx_pkg::OP_LDB_U, ilx_pkg::OP_LDB_UX,
		ilx_pkg::OP_LDH_U, ilx_pkg::OP_LDH_UX};
	wire take       = ready_ff && req_valid;

	// address generation
	// [RQ9] zero base field
	wire        base_zero = (req.base_reg_field == ilx_pkg::GPR_ZERO);
	wire [31:0] base_term = base_zero ? ilx_pkg::ZERO_WORD : req.base_val;
	// [RQ8] sign-extend displacement
	wire [31:0] disp_ext  = {{(ilx_pkg::XLEN - ilx_pkg::DISPW){req.disp[15]}}, req.disp};
	// [RQ1] [RQ2] base plus displacement or index; carry out is dropped (wraps)
	wire [31:0] offset    = op_indexed ? req.index_val : disp_ext;
	wire [31:0] eff_addr  = base_term + offset;
	// [RQ10] one or two byte access
	wire [1:0]  acc_size  = op_half ? ilx_pkg::SIZE_HALF : ilx_pkg::SIZE_BYTE;
	// [RQ7] same base and destination: the loaded value wins, no EA write
	// [RQ6] base zero still updates, writing register zero
	wire        upd_keep  = op_update && (req.base_reg_field != req.dest_field);

	// [RQ3] [RQ4] zero-extend returned element
	wire [31:0] load_val  = half_ff ?
		{{(ilx_pkg::XLEN - ilx_pkg::HALFW){1'b0}}, rsp_data[15:0]} :
		{{(ilx_pkg::XLEN - ilx_pkg::BYTEW){1'b0}}, rsp_data[7:0]};
	wire        done      = (state_ff == ST_WAIT) && rsp_valid;

	// sequencing: one load in flight, ready drops until data returns
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (rsp_valid) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state, handshake and memory request
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_ff     <= ST_IDLE;
			ready_ff     <= 1'b0;
			mem_valid_ff <= 1'b0;
			mem_ff       <= '0;
		end else begin
			state_ff     <= nxt_state;
			ready_ff     <= (nxt_state == ST_IDLE);
			mem_valid_ff <= take;
			if (take) begin
				mem_ff <= '{addr: eff_addr, size: acc_size};
			end
		end
	end

	// per-load context captured at issue
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			half_ff     <= 1'b0;
			upd_ff      <= 1'b0;
			dest_ff     <= 5'h00;
			base_idx_ff <= 5'h00;
		end else if (take) begin
			half_ff     <= op_half;
			upd_ff      <= upd_keep;
			dest_ff     <= req.dest_field;
			base_idx_ff <= req.base_reg_field;
		end
	end

	// write-back pulses on data return
	// [RQ5] EA to base, element to destination
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wb_dest_ff <= '0;
			wb_base_ff <= '0;
		end else begin
			wb_dest_ff <= '{en: done, idx: dest_ff, data: load_val};
			wb_base_ff <= '{en: done && upd_ff, idx: base_idx_ff, data: mem_ff.addr};
		end
	end

	assign req_ready = ready_ff;
	assign mem_valid = mem_valid_ff;
	assign mem       = mem_ff;
	assign wb_dest   = wb_dest_ff;
	assign wb_base   = wb_base_ff;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// [RQ1] displacement address sum
	a_disp_addr_sum: assert property ( // [RQ1]
		take && !op_indexed && !base_zero |=>
		mem_ff.addr == $past(req.base_val) + $past(disp_ext))
		else $error("displacement address wrong");
	// [RQ8] sign extension seen
	a_disp_sign_ext: assert property ( // [RQ8]
		take && !op_indexed && base_zero && req.disp[15] |=> mem_ff.addr[31:16] == 16'hFFFF)
		else $error("displacement not sign-extended");
	// [RQ2] indexed address sum
	a_index_addr_sum: assert property ( // [RQ2]
		take && op_indexed |=> mem_ff.addr == $past(base_term) + $past(req.index_val))
		else $error("indexed address wrong");
	// [RQ9] literal zero base
	a_zero_base_lit: assert property ( // [RQ9]
		take && base_zero |=> mem_ff.addr == $past(offset))
		else $error("zero base field did not add zero");
	// [RQ3] byte zero fill
	a_byte_zero_fill: assert property ( // [RQ3]
		done && !half_ff |=> wb_dest_ff.en && wb_dest_ff.data[31:8] == 24'h000000 &&
		wb_dest_ff.data[7:0] == $past(rsp_data[7:0]))
		else $error("byte load fill wrong");
	// [RQ4] half-word zero fill
	a_half_zero_fill: assert property ( // [RQ4]
		done && half_ff |=> wb_dest_ff.en && wb_dest_ff.data[31:16] == 16'h0000 &&
		wb_dest_ff.data[15:0] == $past(rsp_data[15:0]))
		else $error("half-word load fill wrong");
	// [RQ5] address to base
	a_update_ea_wb: assert property ( // [RQ5]
		wb_base_ff.en |-> wb_dest_ff.en && wb_base_ff.data == mem_ff.addr &&
		wb_base_ff.idx != wb_dest_ff.idx)
		else $error("update write-back wrong");
	// [RQ6] register zero updated
	a_zero_update_ok: assert property ( // [RQ6]
		take && op_update && base_zero && req.dest_field != ilx_pkg::GPR_ZERO |=>
		upd_ff && base_idx_ff == ilx_pkg::GPR_ZERO)
		else $error("base zero update suppressed");
	// [RQ7] loaded data wins
	a_same_reg_load: assert property ( // [RQ7]
		take && op_update && req.base_reg_field == req.dest_field |=> !upd_ff)
		else $error("same register got the address");
	// [RQ10] access size and strobe
	a_access_size_ok: assert property ( // [RQ10]
		take |=> mem_valid_ff && !ready_ff &&
		mem_ff.size == ($past(op_half) ? ilx_pkg::SIZE_HALF : ilx_pkg::SIZE_BYTE))
		else $error("access size or strobe wrong");

	// [RQ5] plain loads skip base
	a_plain_no_base: assert property ( // [RQ5]
		take && !op_update |=> !upd_ff)
		else $error("plain load would write base");
	// [RQ5] update context captured
	a_update_ctx_cap: assert property ( // [RQ5]
		take && upd_keep |=> upd_ff && base_idx_ff == $past(req.base_reg_field) &&
		dest_ff == $past(req.dest_field))
		else $error("update context not captured");
	// [RQ5] one write per load
	a_wb_single_beat: assert property ( // [RQ5]
		wb_dest_ff.en |=> !wb_dest_ff.en && !wb_base_ff.en)
		else $error("write-back pulse too long");
	// [RQ10] one access per load
	a_mem_single_beat: assert property ( // [RQ10]
		mem_valid_ff |=> !mem_valid_ff)
		else $error("memory strobe too long");
	// [RQ10] idle again at write-back
	a_ready_on_wb: assert property ( // [RQ10]
		wb_dest_ff.en |-> ready_ff && !mem_valid_ff)
		else $error("unit not idle at write-back");

	// main scenarios; a memory that never answers leaves all but c_same_reg unreached
	c_byte_load: cover property (take && !op_half ##[1:20] done);
	c_update_zero: cover property (take && op_update && base_zero ##[1:20] wb_base_ff.en);
	c_same_reg: cover property (take && op_update && req.base_reg_field == req.dest_field);
	c_back_to_back: cover property (done ##2 take);
	c_half_indexed: cover property (take && op_half && op_indexed ##[1:20] done);
endmodule

//--- include/ilx_pkg.sv
// shared types and constants for the integer zero-extending load unit
package ilx_pkg;
	localparam int          XLEN      = 32;
	localparam int          REGW      = 5;
	localparam int          DISPW     = 16;
	localparam int          BYTEW     = 8;
	localparam int          HALFW     = 16;
	localparam logic [4:0]  GPR_ZERO  = 5'h00;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	// access size code, in bytes
	localparam logic [1:0]  SIZE_BYTE = 2'h1;
	localparam logic [1:0]  SIZE_HALF = 2'h2;

	// load opcodes handled here: byte/half, displacement/indexed, plain/update
	typedef enum logic [2:0] {
		OP_LDB,
		OP_LDB_X,
		OP_LDB_U,
		OP_LDB_UX,
		OP_LDH,
		OP_LDH_X,
		OP_LDH_U,
		OP_LDH_UX
	} ilx_op_e;

	// decoded load request with register-file operands already read
	typedef struct packed {
		ilx_op_e           op;
		logic [REGW-1:0]   dest_field;
		logic [REGW-1:0]   base_reg_field;
		logic [REGW-1:0]   index_reg_field;
		logic [DISPW-1:0]  disp;
		logic [XLEN-1:0]   base_val;
		logic [XLEN-1:0]   index_val;
	} ilx_req_s;

	// memory access request
	typedef struct packed {
		logic [XLEN-1:0] addr;
		logic [1:0]      size;
	} ilx_mem_s;

	// register file write port
	typedef struct packed {
		logic            en;
		logic [REGW-1:0] idx;
		logic [XLEN-1:0] data;
	} ilx_wb_s;
endpackage

//--- verif/ilx_mem_model.sv
// memory partner for the load unit, answering after a chosen delay
`timescale 1ns/1ps
module ilx_mem_model (
	input  wire logic         sys_clk,   // core clock
	input  wire logic         mem_valid, // request strobe
	input  ilx_pkg::ilx_mem_s mem,       // address and size
	input  wire logic [2:0]   dly,       // extra wait cycles
	output logic              rsp_valid, // data strobe
	output logic [31:0]       rsp_data   // element in low bits, junk above
);
	logic       busy_ff;
	logic [2:0] cnt_ff;
	initial begin
		busy_ff = 1'b0;
		cnt_ff = 3'h0;
		rsp_valid = 1'b0;
		rsp_data = 32'h0;
	end
	// data toggles outside answers so a stale value never passes
	always @(posedge sys_clk) begin
		if (busy_ff && cnt_ff == 3'h0) begin
			rsp_valid <= 1'b1;
			rsp_data <= {~mem.addr[15:0], mem.addr[15:0] ^ 16'h5A3C};
		end else begin
			rsp_valid <= 1'b0;
			rsp_data <= ~rsp_data;
		end
		// an answer in flight survives a reset of the unit on purpose
		if (mem_valid) begin
			busy_ff <= 1'b1;
			cnt_ff <= dly;
		end else if (busy_ff) begin
			busy_ff <= (cnt_ff != 3'h0);
			cnt_ff <= cnt_ff - 3'h1;
		end
	end
endmodule

//--- verif/integer_load_execution_tb.sv
// self-checking bench for the zero-extending load unit
`timescale 1ns/1ps
module integer_load_execution_tb;
	logic              sys_clk, rstn, req_valid, req_ready, mem_valid, rsp_valid, upd;
	logic [31:0]       rsp_data, ea, xd;
	logic [2:0]        dly;
	ilx_pkg::ilx_req_s req;
	ilx_pkg::ilx_req_s rows [8];
	logic [31:0]       row_ea [8];
	ilx_pkg::ilx_mem_s mem;
	ilx_pkg::ilx_wb_s  wb_dest, wb_base;
	int                bad_count, comparisons, i, k;
	ilx_load_unit dut (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .mem_valid(mem_valid), .mem(mem), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .wb_dest(wb_dest), .wb_base(wb_base));
	ilx_mem_model mdl (.sys_clk(sys_clk), .mem_valid(mem_valid), .mem(mem), .dly(dly),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one load; expected EA passed in, the rest from the operands, memory data from the partner's pattern
	task automatic run(input ilx_pkg::ilx_req_s r, input logic [31:0] x_ea);
		for (k = 0; k < 20 && req_ready !== 1'b1; k++) @(negedge sys_clk);
		chk("ready wait", 32'h1, 32'(k < 20));
		if (k == 20) end_sim();
		req = r;
		req_valid = 1'b1;
		@(negedge sys_clk);
		req_valid = 1'b0;
		chk("mem strobe", 32'h1, 32'({req_ready, mem_valid}));
		for (k = 0; k < 20 && wb_dest.en !== 1'b1; k++) @(negedge sys_clk);
		chk("wb wait", 32'h1, 32'(k < 20));
		if (k == 20) end_sim();
		upd = r.op[1] && r.base_reg_field != r.dest_field;
		ea = x_ea;
		xd = r.op[2] ? {16'h0, ea[15:0] ^ 16'h5A3C} : {24'h0, ea[7:0] ^ 8'h3C};
		chk("mem addr", ea, mem.addr);
		chk("mem size", 32'(r.op[2] ? 2'h2 : 2'h1), 32'(mem.size));
		chk("dest idx", 32'(r.dest_field), 32'(wb_dest.idx));
		chk("dest data", xd, wb_dest.data);
		chk("base en", 32'(upd), 32'(wb_base.en));
		if (upd) begin
			chk("base idx", 32'(r.base_reg_field), 32'(wb_base.idx));
			chk("base data", ea, wb_base.data);
		end
	endtask
	initial begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		dly = 3'h0;
		bad_count = 0;
		comparisons = 0;
		// every opcode; base zero, base equal to destination, negative displacement
		rows[0] = '{ilx_pkg::OP_LDB, 5'h03, 5'h04, 5'h00, 16'h8000, 32'h00010000, 32'h0};
		rows[1] = '{ilx_pkg::OP_LDB_X, 5'h05, 5'h00, 5'h06, 16'h0, 32'hFFFFFFFF, 32'h1235};
		rows[2] = '{ilx_pkg::OP_LDB_U, 5'h07, 5'h08, 5'h00, 16'h0011, 32'h100, 32'h0};
		rows[3] = '{ilx_pkg::OP_LDB_UX, 5'h09, 5'h09, 5'h02, 16'h0, 32'h2000, 32'h7F};
		rows[4] = '{ilx_pkg::OP_LDH, 5'h01, 5'h00, 5'h00, 16'hFFFE, 32'hABCD0000, 32'h0};
		rows[5] = '{ilx_pkg::OP_LDH_X, 5'h02, 5'h03, 5'h04, 16'h0, 32'h80000000, 32'h8000002};
		rows[6] = '{ilx_pkg::OP_LDH_U, 5'h0A, 5'h00, 5'h00, 16'h4002, 32'h5555, 32'h0};
		rows[7] = '{ilx_pkg::OP_LDH_UX, 5'h0B, 5'h0C, 5'h0D, 16'h0, 32'hFFFFFFF0, 32'h14};
		// effective address each row must give; the first and the last wrap past the top
		row_ea = '{32'h00008000, 32'h00001235, 32'h00000111, 32'h0000207F,
			32'hFFFFFFFE, 32'h88000002, 32'h00004002, 32'h00000004};
		repeat (3) @(negedge sys_clk);
		chk("ready in reset", 32'h0, 32'({req_ready, mem_valid, wb_dest.en, wb_base.en}));
		rstn = 1'b1;
		// rows back to back, memory answering at three speeds
		for (i = 0; i < 8; i++) begin
			dly = 3'(i % 3);
			run(rows[i], row_ea[i]);
		end
		// update with base and destination both zero: only the loaded byte lands
		rows[0] = '{ilx_pkg::OP_LDB_U, 5'h00, 5'h00, 5'h00, 16'h0123, 32'hFFFF, 32'h0};
		run(rows[0], 32'h00000123);
		// reset in mid-load: the late answer must not reach the idle unit
		dly = 3'h4;
		req = rows[6];
		req_valid = 1'b1;
		@(negedge sys_clk);
		req_valid = 1'b0;
		rstn = 1'b0;
		@(negedge sys_clk);
		chk("ready in reset", 32'h0, 32'(req_ready));
		rstn = 1'b1;
		for (i = 0; i < 8; i++) begin
			@(negedge sys_clk);
			chk("stray wb", 32'h0, 32'({wb_dest.en, wb_base.en, mem_valid}));
		end
		run(rows[7], row_ea[7]);
		end_sim();
	end
endmodule
